// *** rtl/tau_regs.svh ***
// Register map, field positions and reset values of the table access unit.
// Assumes inclusion by bare name from the unit's package or design file.
`ifndef TAU_REGS_SVH
`define TAU_REGS_SVH

// Byte addresses on the register bus
`define TAU_RESET_CTRL_OFS 8'h08
`define TAU_LATCH_OFS 8'h0c
`define TAU_PTR_LOW_OFS 8'h10
`define TAU_PTR_HIGH_OFS 8'h14
`define TAU_PTR_UPPER_OFS 8'h18
`define TAU_CMD_OFS 8'h1c
`define TAU_STATUS_OFS 8'h20

// Reset control fields
`define TAU_PRIO_BIT 7
`define TAU_LWE_BIT 6
`define TAU_UNIMPL_BIT 5
`define TAU_FLAGS_RST 5'h1c

// Command fields
`define TAU_CMD_READ_BIT 0
`define TAU_CMD_WRITE_BIT 1
`define TAU_CMD_MODE_LSB 2

// Status fields
`define TAU_ST_BUSY_BIT 0
`define TAU_ST_LONG_BIT 1
`define TAU_ST_BLOCK_BIT 2
`define TAU_ST_VPP_BIT 3

// Bus responses
`define TAU_RESP_OKAY 2'h0
`define TAU_RESP_SLVERR 2'h2

`endif

// *** rtl/tau_pkg.sv ***
// Types shared by the table access unit.
// Assumes the register map header sits beside it.
`default_nettype none
package tau_pkg;
    // Sequencer states, one-hot
    typedef enum logic [2:0]
    {
        TAU_ST_IDLE = 3'h1,
        TAU_ST_READ = 3'h2,
        TAU_ST_PROG = 3'h4
    } tau_state_t;

    // Pointer update forms
    typedef enum logic [1:0]
    {
        TAU_MODE_KEEP = 2'h0,
        TAU_MODE_POST_INC = 2'h1,
        TAU_MODE_POST_DEC = 2'h2,
        TAU_MODE_PRE_INC = 2'h3
    } tau_mode_t;
endpackage : tau_pkg
`default_nettype wire

// *** rtl/tau_top.sv ***
// Table access unit: byte moves between program memory and registers, AXI4-Lite slave.
// Assumes a program memory port that answers reads and long writes by handshake,
// and pins for the programming voltage detect and the master clear reset.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "tau_regs.svh"

// Contract
// RULE_01: Write enable plus VPP allows long writes
// RULE_02: Long write enable cleared only by reset
// RULE_03: Long write enable gates program memory writes
// RULE_04: Reset control at 08h, fields bit7..bit0
// RULE_05: Unimplemented bit ignores writes, reads zero
// RULE_06: Eight-bit read/write table latch
// RULE_07: Pointer joins three bytes into 22 bits
// RULE_08: Low 21 bits address program bytes
// RULE_09: Top bit selects configuration space
// RULE_10: Automatic updates leave top bit alone
// RULE_11: Plain form keeps pointer unchanged
// RULE_12: Post-increment adds one after transfer
// RULE_13: Post-decrement subtracts one after transfer
// RULE_14: Pre-increment adds one before transfer
// RULE_15: Read loads addressed byte into latch
// RULE_16: One byte per read, any alignment
// RULE_17: Even write copies latch to holding
// RULE_18: Odd write programs latch high, holding low
// RULE_19: Without enable only short writes occur
// RULE_20: Low field wraps, no carry into top
module tau_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [21:0] pm_addr,
    output logic pm_cfg_space,
    output logic pm_rd_req,
    input wire logic [7:0] pm_rd_data,
    input wire logic pm_rd_valid,
    output logic pm_wr_req,
    output logic [15:0] pm_wr_word,
    input wire logic pm_wr_done,
    input wire logic vpp_present,
    input wire logic master_clear_pin_n,
    output logic long_write_enable,
    output logic priority_levels_enable
);
    import tau_pkg::*;

    tau_state_t state_q;
    tau_mode_t mode_q;
    tau_mode_t cmd_mode;
    logic [21:0] table_pointer_q;
    logic [21:0] acc_addr;
    logic [21:0] pm_addr_q;
    logic [7:0] table_data_latch_q;
    logic [7:0] holding_q;
    logic [15:0] pm_wr_word_q;
    logic prio_q;
    logic lwe_q;
    logic [4:0] flags_q;
    logic last_long_q;
    logic last_block_q;
    logic vpp_s1_q;
    logic vpp_s2_q;
    logic mcp_s1_q;
    logic mcp_s2_q;
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rd_rctl_q;
    logic wr_fire;
    logic wr_en;
    logic cmd_rd;
    logic cmd_wr;
    logic long_ok;
    logic ptr_sw_wr;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic wr_hit;

    // Low-field step with wrap; the top bit is carried over untouched
    function automatic logic [21:0] tau_step(input logic [21:0] p, input logic up);
        logic [20:0] low;
        low = up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001;
        return {p[21], low}; // [RULE_10] [RULE_20]
    endfunction : tau_step

    // Pointer after the transfer for the post forms
    function automatic logic [21:0] tau_post(input logic [21:0] p, input tau_mode_t m);
        logic [21:0] r;
        r = p;
        if (m == TAU_MODE_POST_INC)
        begin
            r = tau_step(p, 1'b1); // [RULE_12]
        end
        else if (m == TAU_MODE_POST_DEC)
        begin
            r = tau_step(p, 1'b0); // [RULE_13]
        end
        return r; // [RULE_11]
    endfunction : tau_post

    // Pin synchronisers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            vpp_s1_q <= 1'b0;
            vpp_s2_q <= 1'b0;
            mcp_s1_q <= 1'b1;
            mcp_s2_q <= 1'b1;
        end
        else
        begin
            vpp_s1_q <= vpp_present;
            vpp_s2_q <= vpp_s1_q;
            mcp_s1_q <= master_clear_pin_n;
            mcp_s2_q <= mcp_s1_q;
        end
    end

    // Write channel decode
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign wr_en = wr_fire && w_lane_q;
    assign wr_hit = (aw_addr_q == `TAU_RESET_CTRL_OFS) || (aw_addr_q == `TAU_LATCH_OFS)
        || (aw_addr_q == `TAU_PTR_LOW_OFS) || (aw_addr_q == `TAU_PTR_HIGH_OFS)
        || (aw_addr_q == `TAU_PTR_UPPER_OFS) || (aw_addr_q == `TAU_CMD_OFS)
        || (aw_addr_q == `TAU_STATUS_OFS);
    assign cmd_mode = tau_mode_t'(w_data_q[`TAU_CMD_MODE_LSB +: 2]);
    assign cmd_rd = wr_en && (aw_addr_q == `TAU_CMD_OFS) && (state_q == TAU_ST_IDLE)
        && w_data_q[`TAU_CMD_READ_BIT];
    assign cmd_wr = wr_en && (aw_addr_q == `TAU_CMD_OFS) && (state_q == TAU_ST_IDLE)
        && !w_data_q[`TAU_CMD_READ_BIT] && w_data_q[`TAU_CMD_WRITE_BIT];
    assign ptr_sw_wr = wr_en && (state_q == TAU_ST_IDLE) && ((aw_addr_q == `TAU_PTR_LOW_OFS)
        || (aw_addr_q == `TAU_PTR_HIGH_OFS) || (aw_addr_q == `TAU_PTR_UPPER_OFS));
    // Transfer address: pre-increment steps first
    assign acc_addr = (cmd_mode == TAU_MODE_PRE_INC) ? tau_step(table_pointer_q, 1'b1)
        : table_pointer_q; // [RULE_14]
    assign long_ok = lwe_q && vpp_s2_q; // [RULE_01] [RULE_03]

    // Bus handshakes
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Write address and data capture, response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `TAU_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end
            if (wr_fire)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `TAU_RESP_OKAY : `TAU_RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Register read mux; unused upper bits read zero
    always_comb
    begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `TAU_RESET_CTRL_OFS: rd_byte = {prio_q, lwe_q, 1'b0, flags_q}; // [RULE_04] [RULE_05]
            `TAU_LATCH_OFS: rd_byte = table_data_latch_q; // [RULE_06]
            `TAU_PTR_LOW_OFS: rd_byte = table_pointer_q[7:0];
            `TAU_PTR_HIGH_OFS: rd_byte = table_pointer_q[15:8];
            `TAU_PTR_UPPER_OFS: rd_byte = {2'h0, table_pointer_q[21:16]};
            `TAU_CMD_OFS: rd_byte = 8'h00;
            `TAU_STATUS_OFS: rd_byte = {4'h0, vpp_s2_q, last_block_q, last_long_q, state_q != TAU_ST_IDLE};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `TAU_RESP_OKAY;
            rd_rctl_q <= 1'b0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h000000, rd_byte};
            rresp_q <= rd_hit ? `TAU_RESP_OKAY : `TAU_RESP_SLVERR;
            rd_rctl_q <= (s_axi_araddr == `TAU_RESET_CTRL_OFS);
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // Reset control register: write enable is set-only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prio_q <= 1'b0;
            lwe_q <= 1'b0;
            flags_q <= `TAU_FLAGS_RST;
        end
        else
        begin
            if (!mcp_s2_q)
            begin
                lwe_q <= 1'b0; // [RULE_02]
            end
            else if (wr_en && aw_addr_q == `TAU_RESET_CTRL_OFS && w_data_q[`TAU_LWE_BIT])
            begin
                lwe_q <= 1'b1; // [RULE_02]
            end
            if (wr_en && aw_addr_q == `TAU_RESET_CTRL_OFS)
            begin
                prio_q <= w_data_q[`TAU_PRIO_BIT]; // [RULE_04]
                flags_q <= w_data_q[4:0];
            end
        end
    end

    // Pointer, latch, holding register and transfer sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= TAU_ST_IDLE;
            mode_q <= TAU_MODE_KEEP;
            table_pointer_q <= 22'h000000;
            pm_addr_q <= 22'h000000;
            table_data_latch_q <= 8'h00;
            holding_q <= 8'h00;
            pm_wr_word_q <= 16'h0000;
            last_long_q <= 1'b0;
            last_block_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                TAU_ST_IDLE:
                begin
                    if (wr_en && aw_addr_q == `TAU_LATCH_OFS)
                    begin
                        table_data_latch_q <= w_data_q; // [RULE_06]
                    end
                    if (ptr_sw_wr && aw_addr_q == `TAU_PTR_LOW_OFS)
                    begin
                        table_pointer_q[7:0] <= w_data_q; // [RULE_07]
                    end
                    if (ptr_sw_wr && aw_addr_q == `TAU_PTR_HIGH_OFS)
                    begin
                        table_pointer_q[15:8] <= w_data_q; // [RULE_07]
                    end
                    if (ptr_sw_wr && aw_addr_q == `TAU_PTR_UPPER_OFS)
                    begin
                        table_pointer_q[21:16] <= w_data_q[5:0]; // [RULE_07]
                    end
                    if (cmd_rd)
                    begin
                        // Any byte address is fetched, no alignment
                        mode_q <= cmd_mode;
                        pm_addr_q <= acc_addr; // [RULE_08] [RULE_09] [RULE_16]
                        table_pointer_q <= acc_addr; // [RULE_14]
                        state_q <= TAU_ST_READ;
                    end
                    else if (cmd_wr)
                    begin
                        mode_q <= cmd_mode;
                        pm_addr_q <= acc_addr;
                        last_long_q <= 1'b0;
                        last_block_q <= 1'b0;
                        if (!acc_addr[0])
                        begin
                            holding_q <= table_data_latch_q; // [RULE_17]
                            table_pointer_q <= tau_post(acc_addr, cmd_mode);
                        end
                        else if (long_ok)
                        begin
                            pm_wr_word_q <= {table_data_latch_q, holding_q}; // [RULE_18]
                            table_pointer_q <= acc_addr;
                            last_long_q <= 1'b1;
                            state_q <= TAU_ST_PROG; // [RULE_01] [RULE_03]
                        end
                        else
                        begin
                            last_block_q <= 1'b1; // [RULE_19]
                            table_pointer_q <= tau_post(acc_addr, cmd_mode);
                        end
                    end
                end
                TAU_ST_READ:
                begin
                    if (pm_rd_valid)
                    begin
                        table_data_latch_q <= pm_rd_data; // [RULE_15]
                        table_pointer_q <= tau_post(table_pointer_q, mode_q);
                        state_q <= TAU_ST_IDLE;
                    end
                end
                TAU_ST_PROG:
                begin
                    if (pm_wr_done)
                    begin
                        table_pointer_q <= tau_post(table_pointer_q, mode_q);
                        state_q <= TAU_ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= TAU_ST_IDLE;
                end
            endcase
        end
    end

    // Program memory side
    assign pm_addr = pm_addr_q;
    assign pm_cfg_space = pm_addr_q[21]; // [RULE_09]
    assign pm_rd_req = (state_q == TAU_ST_READ);
    assign pm_wr_req = (state_q == TAU_ST_PROG);
    assign pm_wr_word = pm_wr_word_q;
    assign long_write_enable = lwe_q;
    assign priority_levels_enable = prio_q;

    lwe_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_02]
        lwe_q && mcp_s2_q |=> lwe_q)
        else $error("long write enable dropped without master clear");
    unimpl_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_05]
        rvalid_q && rd_rctl_q |-> rdata_q[`TAU_UNIMPL_BIT] == 1'b0)
        else $error("unimplemented reset control bit read as one");
    prog_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
        $rose(pm_wr_req) |-> $past(lwe_q) && $past(vpp_s2_q) && pm_addr_q[0])
        else $error("long write started without enable, voltage or odd address");
    top_bit_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_10]
        !ptr_sw_wr |=> table_pointer_q[21] == $past(table_pointer_q[21]))
        else $error("pointer top bit changed by an automatic update");
    post_inc_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_12]
        pm_rd_req && pm_rd_valid && mode_q == TAU_MODE_POST_INC
        |=> table_pointer_q[20:0] == 21'($past(pm_addr_q[20:0]) + 21'h000001))
        else $error("post-increment read did not advance pointer by one");
    pre_inc_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_14]
        (cmd_rd || cmd_wr) && cmd_mode == TAU_MODE_PRE_INC
        |=> pm_addr_q[20:0] == 21'($past(table_pointer_q[20:0]) + 21'h000001))
        else $error("pre-increment transfer used the old pointer");
    read_latch_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_15]
        pm_rd_req && pm_rd_valid |=> table_data_latch_q == $past(pm_rd_data) && !pm_rd_req)
        else $error("read byte not loaded into latch");
    even_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_17]
        cmd_wr && !acc_addr[0] |=> holding_q == $past(table_data_latch_q) && !pm_wr_req)
        else $error("even write did not fill holding register");
    long_word_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_18]
        $rose(pm_wr_req) |-> pm_wr_word == {$past(table_data_latch_q), $past(holding_q)})
        else $error("long write word not latch over holding");
    short_only_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_19]
        cmd_wr && !lwe_q |=> !pm_wr_req [*2])
        else $error("program write started with enable clear");
endmodule : tau_top
`default_nettype wire

// *** verif/tau_pmem_model.sv ***
// Program memory model: a byte array that answers reads and long writes by handshake.
// Assumes the table access unit holds its requests as levels until the one-cycle answer.
`timescale 1ns/100ps
`default_nettype none
module tau_pmem_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] lat,
    input wire logic [21:0] pm_addr,
    input wire logic pm_cfg_space,
    input wire logic pm_rd_req,
    output logic [7:0] pm_rd_data,
    output logic pm_rd_valid,
    input wire logic pm_wr_req,
    input wire logic [15:0] pm_wr_word,
    output logic pm_wr_done
);
    logic [7:0] mem [512];
    logic [2:0] cnt_q;

    // Fixed pattern that the bench knows as well
    initial
    begin
        for (int i = 0; i < 512; i++)
            mem[i] = 8'(i * 37 + 11);
    end

    // Answer lat + 1 cycles after the request is first seen; idle data toggles so a stale byte is never taken
    always @(posedge aclk)
    begin
        pm_rd_valid <= 1'b0;
        pm_wr_done <= 1'b0;
        pm_rd_data <= ~pm_rd_data;
        if (!aresetn)
        begin
            cnt_q <= 3'h0;
            pm_rd_data <= 8'h5a;
        end
        else if ((pm_rd_req && !pm_rd_valid) || (pm_wr_req && !pm_wr_done))
        begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q >= lat)
            begin
                cnt_q <= 3'h0;
                if (pm_rd_req)
                begin
                    pm_rd_valid <= 1'b1;
                    pm_rd_data <= mem[{pm_cfg_space, pm_addr[7:0]}];
                end
                else
                begin
                    pm_wr_done <= 1'b1;
                    mem[{pm_cfg_space, pm_addr[7:0]}] <= pm_wr_word[15:8];
                    mem[{pm_cfg_space, pm_addr[7:1], 1'b0}] <= pm_wr_word[7:0];
                end
            end
        end
    end
endmodule : tau_pmem_model
`default_nettype wire

// *** verif/tb.sv ***
// Bench for the table access unit: bus master, reference model of the unit, checks.
// Assumes the program memory model beside it and the unit's register map header.
`timescale 1ns/100ps
`default_nettype none
`include "tau_regs.svh"
module tb;
    import tau_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, pm_rd_data;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, last_resp;
    logic [3:0] wstrb;
    logic [21:0] pm_addr, m_ptr;
    logic pm_cfg_space, pm_rd_req, pm_rd_valid, pm_wr_req, pm_wr_done, vpp_present, master_clear_pin_n;
    logic long_write_enable, priority_levels_enable, wr_req_d = 1'b0;
    logic [15:0] pm_wr_word;
    logic [2:0] lat;
    logic [31:0] st = 32'h1;
    logic [7:0] m_latch, m_hold;
    logic [7:0] m_mem [512];
    bit m_lwe;
    int errors, checks_done, wr_starts, m_longs;
    logic [21:0] bp [4] = '{22'h1fffff, 22'h200000, 22'h3fffff, 22'h0};
    logic [1:0] bm [4] = '{2'h1, 2'h2, 2'h3, 2'h2};

    tau_top dut_u
    (
        .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pm_addr, .pm_cfg_space, .pm_rd_req, .pm_rd_data,
        .pm_rd_valid, .pm_wr_req, .pm_wr_word, .pm_wr_done, .vpp_present, .master_clear_pin_n,
        .long_write_enable, .priority_levels_enable
    );

    tau_pmem_model pm_u
    (
        .aclk, .aresetn, .lat, .pm_addr, .pm_cfg_space, .pm_rd_req, .pm_rd_data, .pm_rd_valid,
        .pm_wr_req, .pm_wr_word, .pm_wr_done
    );

    // Clock at 10 MHz
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // Count long writes that actually start at the memory port
    always @(posedge aclk)
    begin
        if (pm_wr_req && !wr_req_d)
            wr_starts++;
        wr_req_d <= pm_wr_req;
    end

    function automatic logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction : rnd

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Write one register; each channel is released at the edge that takes it
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                last_resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                d = rdata;
                last_resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : bus_rd

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [31:0] d;
        bus_rd(a, d);
        check(d, {24'h0, exp}, what);
    endtask : rd_chk

    // One table operation through the unit, mirrored by the model, then every result compared
    task automatic do_op(input bit rd, input logic [1:0] md, input logic [21:0] p, input logic [7:0] ld);
        logic [31:0] s;
        logic [8:0] ix;
        bit lng;
        bit odd;
        bus_wr(`TAU_PTR_LOW_OFS, p[7:0]);
        bus_wr(`TAU_PTR_HIGH_OFS, p[15:8]);
        bus_wr(`TAU_PTR_UPPER_OFS, {2'h0, p[21:16]});
        bus_wr(`TAU_LATCH_OFS, ld);
        lat <= 3'(rnd());
        bus_wr(`TAU_CMD_OFS, {4'h0, md, !rd || st[0], rd});
        do
            bus_rd(`TAU_STATUS_OFS, s);
        while (s[0] !== 1'b0);
        m_ptr = p;
        m_latch = ld;
        if (md == TAU_MODE_PRE_INC)
            m_ptr[20:0] = m_ptr[20:0] + 21'h1;
        ix = {m_ptr[21], m_ptr[7:0]};
        odd = m_ptr[0];
        lng = !rd && odd && m_lwe && vpp_present;
        if (rd)
            m_latch = m_mem[ix];
        else if (!odd)
            m_hold = m_latch;
        else if (lng)
        begin
            m_mem[ix] = m_latch;
            m_mem[ix - 9'h1] = m_hold;
            m_longs++;
        end
        if (md == TAU_MODE_POST_INC)
            m_ptr[20:0] = m_ptr[20:0] + 21'h1;
        if (md == TAU_MODE_POST_DEC)
            m_ptr[20:0] = m_ptr[20:0] - 21'h1;
        if (!rd)
            check({29'h0, s[3:1]}, {29'h0, vpp_present, odd && !lng, lng}, "status");
        rd_chk(`TAU_LATCH_OFS, m_latch, "latch");
        rd_chk(`TAU_PTR_LOW_OFS, m_ptr[7:0], "ptr low");
        rd_chk(`TAU_PTR_HIGH_OFS, m_ptr[15:8], "ptr high");
        rd_chk(`TAU_PTR_UPPER_OFS, {2'h0, m_ptr[21:16]}, "ptr upper");
    endtask : do_op

    // Watchdog far beyond the few thousand cycles the sequence needs
    initial
    begin
        repeat (30000) @(posedge aclk);
        errors++;
        $display("BAD watchdog expired");
        tally_and_finish();
    end

    initial
    begin
        logic [31:0] d;
        logic [21:0] base;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        {vpp_present, lat, aresetn} = '0;
        wstrb = 4'hf;
        master_clear_pin_n = 1'b1;
        for (int i = 0; i < 512; i++)
            m_mem[i] = 8'(i * 37 + 11);
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`TAU_RESET_CTRL_OFS, 8'h1c, "reset ctrl");
        rd_chk(`TAU_LATCH_OFS, 8'h0, "latch reset");
        rd_chk(`TAU_PTR_UPPER_OFS, 8'h0, "ptr reset");
        bus_wr(8'h40, 8'hff);
        check({30'h0, last_resp}, {30'h0, `TAU_RESP_SLVERR}, "unmapped wr resp");
        bus_rd(8'h40, d);
        check({d[31:2], last_resp}, {30'h0, `TAU_RESP_SLVERR}, "unmapped rd");
        bus_wr(`TAU_RESET_CTRL_OFS, 8'hbf);
        // A write without lane zero must leave the register alone
        wstrb <= 4'he;
        bus_wr(`TAU_RESET_CTRL_OFS, 8'h00);
        wstrb <= 4'hf;
        check({30'h0, last_resp}, {30'h0, `TAU_RESP_OKAY}, "masked wr resp");
        rd_chk(`TAU_RESET_CTRL_OFS, 8'h9f, "reset ctrl");
        check({31'h0, priority_levels_enable}, 32'h1, "prio out");
        // Reads in every pointer form, boundary pointers first
        for (int i = 0; i < 20; i++)
            do_op(1'b1, i < 4 ? bm[i] : 2'(rnd()), i < 4 ? bp[i] : 22'(rnd()), 8'(rnd()));
        // Writes with the enable clear stay short
        vpp_present <= 1'b1;
        do_op(1'b0, TAU_MODE_POST_INC, 22'h10, 8'(rnd()));
        do_op(1'b0, TAU_MODE_KEEP, 22'h11, 8'(rnd()));
        check(32'(wr_starts), 32'h0, "blocked writes");
        bus_wr(`TAU_RESET_CTRL_OFS, 8'hff);
        m_lwe = 1'b1;
        rd_chk(`TAU_RESET_CTRL_OFS, 8'hdf, "reset ctrl");
        // Pairs of writes in every form; one pair without programming voltage
        for (int j = 0; j < 4; j++)
        begin
            vpp_present <= (j != 2);
            d = rnd();
            base = {d[0], 13'h0, d[8:2], 1'b0};
            do_op(1'b0, TAU_MODE_POST_INC, base, 8'(rnd()));
            do_op(1'b0, 2'(j), j == 3 ? base : base + 22'h1, 8'(rnd()));
            do_op(1'b1, TAU_MODE_KEEP, base, 8'h0);
            do_op(1'b1, TAU_MODE_KEEP, base + 22'h1, 8'h0);
        end
        check(32'(wr_starts), 32'(m_longs), "long writes");
        bus_wr(`TAU_RESET_CTRL_OFS, 8'h00);
        rd_chk(`TAU_RESET_CTRL_OFS, 8'h40, "no sw clear");
        master_clear_pin_n <= 1'b0;
        repeat (6) @(posedge aclk);
        master_clear_pin_n <= 1'b1;
        m_lwe = 1'b0;
        check({31'h0, long_write_enable}, 32'h0, "pin clear");
        rd_chk(`TAU_RESET_CTRL_OFS, 8'h00, "pin clear");
        do_op(1'b0, TAU_MODE_KEEP, 22'h21, 8'(rnd()));
        check(32'(wr_starts), 32'(m_longs), "long writes");
        // Power-on reset in mid-run clears the set-only enable
        bus_wr(`TAU_RESET_CTRL_OFS, 8'h40);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`TAU_RESET_CTRL_OFS, 8'h1c, "por clear");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
